// [rtl/pfc_pkg.sv]
// shared constants, types and command encodings for the parallel flash command host
`default_nettype none
package pfc_pkg;
	// ************************************************************
	// clock and pin timing
	// ************************************************************
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned T_WP_NS = 45; // write strobe low, least
	localparam int unsigned T_WPH_NS = 45; // write strobe high, least
	localparam int unsigned T_ACC_NS = 45; // chip enable access, longest
	localparam int unsigned T_HZ_NS = 20; // output turn-off after strobe high
	localparam int unsigned SYNC_STAGES = 3;
	localparam int unsigned WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RD_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES + 1;
	localparam int unsigned GAP_CYC = (T_HZ_NS * CLK_MHZ + 999) / 1000;

	// ************************************************************
	// operation timing (long counts become top-level parameters)
	// ************************************************************
	localparam int unsigned PROG_MAX_US = 50;
	localparam int unsigned ERASE_MAX_S = 1;
	localparam int unsigned POWERUP_WRITE_DELAY_MS = 5;
	localparam int unsigned POWERUP_READ_DELAY_US = 100;
	localparam int unsigned PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
	localparam int unsigned ERASE_MAX_CYC = ERASE_MAX_S * CLK_MHZ * 1000000;
	localparam int unsigned PU_WRITE_CYC = POWERUP_WRITE_DELAY_MS * CLK_MHZ * 1000;
	localparam int unsigned PU_READ_CYC = POWERUP_READ_DELAY_US * CLK_MHZ;

	// ************************************************************
	// command cycle codes
	// ************************************************************
	localparam logic [15:0] ADDR_UNLOCK1 = 16'h5555;
	localparam logic [15:0] ADDR_UNLOCK2 = 16'h2AAA;
	localparam logic [15:0] ADDR_LOCK_QUERY = 16'h0002;
	localparam logic [15:0] ADDR_BOOT_END = 16'h1FFF;
	localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
	localparam logic [7:0] CODE_ERASE_PRE = 8'h80;
	localparam logic [7:0] CODE_PROGRAM = 8'hA0;
	localparam logic [7:0] CODE_ID_ENTER = 8'h90;
	localparam logic [7:0] CODE_ID_EXIT = 8'hF0;
	localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CODE_MAIN_ERASE = 8'h30;
	localparam logic [7:0] CODE_LOCKOUT = 8'h40;
	localparam logic [7:0] LOCK_ACTIVE = 8'hFF;
	localparam logic [7:0] LOCK_INACTIVE = 8'hFE;
	localparam int unsigned TOGGLE_BIT = 6;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_CHIP_ERASE = 3'h2,
		OP_MAIN_ERASE = 3'h3,
		OP_LOCKOUT = 3'h4,
		OP_ID_ENTER = 3'h5,
		OP_ID_EXIT3 = 3'h6,
		OP_ID_EXIT1 = 3'h7
	} pfc_op_t;

	typedef struct packed {
		pfc_op_t op;
		logic [15:0] addr;
		logic [15:0] data;
	} pfc_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} pfc_cycle_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic dq_oe_n;
		logic [15:0] addr;
		logic [15:0] dq;
	} pfc_pins_t;

	localparam pfc_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
		addr: 16'h0000, dq: 16'h0000};
endpackage : pfc_pkg
`default_nettype wire

// [rtl/pfc_host.sv]
// host-side sequencer that drives command cycles and polling on a parallel flash
`default_nettype none
module pfc_host
	import pfc_pkg::*;
#(
	parameter int unsigned PROG_TIMEOUT = PROG_MAX_CYC,
	parameter int unsigned ERASE_TIMEOUT = ERASE_MAX_CYC,
	parameter int unsigned PU_WRITE_WAIT = PU_WRITE_CYC,
	parameter int unsigned PU_READ_WAIT = PU_READ_CYC
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire logic I_REQ_VALID,
	input wire pfc_req_t I_REQ,
	output logic O_REQ_READY,
	output logic O_DONE,
	output logic O_ERR,
	output logic [15:0] O_RDATA,
	output logic O_ID_MODE,
	output logic O_LOCKED,
	output logic O_CE_N,
	output logic O_OE_N,
	output logic O_WE_N,
	output logic [15:0] O_ADDR,
	output logic [15:0] O_DQ,
	output logic O_DQ_OE_N,
	input wire logic [15:0] I_DQ
);
	// ************************************************************
	// command cycle tables
	// ************************************************************
	// address and data of a given cycle of a command; code cycles send a zero upper data byte, the program cycle sends the request address and data whole
	function automatic pfc_cycle_t seq_cycle(input pfc_op_t op, input logic [2:0] step, input pfc_req_t rq);
		pfc_cycle_t c;
		c = '{addr: ADDR_UNLOCK1, data: {8'h00, CODE_UNLOCK1}};
		if (op == OP_ID_EXIT1) begin
			c = '{addr: rq.addr, data: {8'h00, CODE_ID_EXIT}};
		end else begin
			unique case (step)
				3'h1, 3'h4: c = '{addr: ADDR_UNLOCK2, data: {8'h00, CODE_UNLOCK2}};
				3'h2: begin
					unique case (op)
						OP_PROGRAM: c.data = {8'h00, CODE_PROGRAM};
						OP_ID_ENTER: c.data = {8'h00, CODE_ID_ENTER};
						OP_ID_EXIT3: c.data = {8'h00, CODE_ID_EXIT};
						default: c.data = {8'h00, CODE_ERASE_PRE};
					endcase
				end
				3'h3: begin
					if (op == OP_PROGRAM) begin
						c = '{addr: rq.addr, data: rq.data};
					end
				end
				3'h5: begin
					unique case (op)
						OP_CHIP_ERASE: c.data = {8'h00, CODE_CHIP_ERASE};
						OP_MAIN_ERASE: c.data = {8'h00, CODE_MAIN_ERASE};
						default: c.data = {8'h00, CODE_LOCKOUT};
					endcase
				end
				default: c = '{addr: ADDR_UNLOCK1, data: {8'h00, CODE_UNLOCK1}};
			endcase
		end
		return c;
	endfunction

	// number of write cycles of a command
	function automatic logic [2:0] seq_len(input pfc_op_t op);
		logic [2:0] n;
		n = 3'h0;
		unique case (op)
			OP_CHIP_ERASE, OP_MAIN_ERASE, OP_LOCKOUT: n = 3'h6;
			OP_PROGRAM: n = 3'h4;
			OP_ID_ENTER, OP_ID_EXIT3: n = 3'h3;
			OP_ID_EXIT1: n = 3'h1;
			OP_READ: n = 3'h0;
		endcase
		return n;
	endfunction

	// ************************************************************
	// state and registers
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WR_LOW = 3'h1,
		ST_WR_HIGH = 3'h2,
		ST_RD_LOW = 3'h3,
		ST_RD_HIGH = 3'h4,
		ST_POLL = 3'h5,
		ST_FINISH = 3'h6
	} pfc_state_t;

	pfc_state_t state_reg, state_next;
	pfc_pins_t pins_reg, pins_next;
	pfc_req_t req_reg, req_next;
	logic [2:0] step_reg, step_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [31:0] tmo_reg, tmo_next;
	logic [31:0] pu_reg;
	logic [15:0] rdata_reg, rdata_next;
	logic [15:0] prev_reg, prev_next;
	logic poll_reg, poll_next;
	logic first_reg, first_next;
	logic err_reg, err_next;
	logic id_reg, id_next;
	logic lock_reg, lock_next;
	logic [15:0] dq_m1_reg, dq_m2_reg, dq_m3_reg, dq_stable_reg;

	// ************************************************************
	// decode
	// ************************************************************
	wire logic rd_ok = pu_reg >= 32'(PU_READ_WAIT);
	wire logic wr_ok = pu_reg >= 32'(PU_WRITE_WAIT);
	wire logic is_wr = I_REQ.op != OP_READ;
	wire logic accept = I_REQ_VALID && O_REQ_READY;
	wire logic polled_op = req_reg.op inside {OP_PROGRAM, OP_CHIP_ERASE, OP_MAIN_ERASE, OP_LOCKOUT};
	wire logic boot_hit = lock_reg && (I_REQ.addr <= ADDR_BOOT_END);
	wire logic [31:0] tmo_lim = (req_reg.op == OP_PROGRAM) ? 32'(PROG_TIMEOUT) : 32'(ERASE_TIMEOUT);
	wire logic [2:0] step_inc = step_reg + 3'h1;
	wire pfc_cycle_t cyc_first = seq_cycle(I_REQ.op, 3'h0, I_REQ);
	wire pfc_cycle_t cyc_next = seq_cycle(req_reg.op, step_inc, req_reg);
	// toggling stopped: two successive poll reads agree on the toggle bit
	wire logic settled = (rdata_reg[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]);
	wire logic is_query = id_reg && (req_reg.addr == ADDR_LOCK_QUERY);

	assign O_REQ_READY = (state_reg == ST_IDLE) && (is_wr ? wr_ok : rd_ok);
	assign O_DONE = state_reg == ST_FINISH;
	assign O_ERR = err_reg;
	assign O_RDATA = rdata_reg;
	assign O_ID_MODE = id_reg;
	assign O_LOCKED = lock_reg;
	assign O_CE_N = pins_reg.ce_n;
	assign O_OE_N = pins_reg.oe_n;
	assign O_WE_N = pins_reg.we_n;
	assign O_ADDR = pins_reg.addr;
	assign O_DQ = pins_reg.dq;
	assign O_DQ_OE_N = pins_reg.dq_oe_n;

	// ************************************************************
	// sequencer
	// ************************************************************
	// one strobe phase per state; the counter times each phase, the timeout spans the whole poll
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		req_next = req_reg;
		step_next = step_reg;
		cnt_next = cnt_reg + 32'h1;
		tmo_next = poll_reg ? tmo_reg + 32'h1 : 32'h0;
		rdata_next = rdata_reg;
		prev_next = prev_reg;
		poll_next = poll_reg;
		first_next = first_reg;
		err_next = err_reg;
		id_next = id_reg;
		lock_next = lock_reg;
		unique case (state_reg)
			ST_IDLE: begin
				cnt_next = 32'h0;
				if (accept) begin
					req_next = I_REQ;
					step_next = 3'h0;
					err_next = 1'b0;
					poll_next = 1'b0;
					if (I_REQ.op == OP_READ) begin
						pins_next = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, dq_oe_n: 1'b1,
							addr: I_REQ.addr, dq: 16'h0000};
						state_next = ST_RD_LOW;
					end else if (I_REQ.op == OP_PROGRAM && boot_hit) begin
						err_next = 1'b1;
						state_next = ST_FINISH;
					end else begin
						pins_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, dq_oe_n: 1'b0,
							addr: cyc_first.addr, dq: cyc_first.data};
						state_next = ST_WR_LOW;
					end
				end
			end
			ST_WR_LOW: begin
				if (cnt_reg >= 32'(WP_CYC - 1)) begin
					pins_next.ce_n = 1'b1;
					pins_next.we_n = 1'b1;
					cnt_next = 32'h0;
					state_next = ST_WR_HIGH;
				end
			end
			ST_WR_HIGH: begin
				// address and data are held through the high phase to cover hold time
				if (cnt_reg >= 32'(WPH_CYC - 1)) begin
					cnt_next = 32'h0;
					step_next = step_inc;
					if (step_inc < seq_len(req_reg.op)) begin
						pins_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, dq_oe_n: 1'b0,
							addr: cyc_next.addr, dq: cyc_next.data};
						state_next = ST_WR_LOW;
					end else if (polled_op) begin
						pins_next = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, dq_oe_n: 1'b1,
							addr: pins_reg.addr, dq: 16'h0000};
						poll_next = 1'b1;
						first_next = 1'b1;
						state_next = ST_RD_LOW;
					end else begin
						pins_next = PINS_IDLE;
						if (req_reg.op == OP_ID_ENTER) begin
							id_next = 1'b1;
						end else begin
							id_next = 1'b0;
						end
						state_next = ST_FINISH;
					end
				end
			end
			ST_RD_LOW: begin
				// wait covers access time plus the input synchroniser
				if (cnt_reg >= 32'(RD_CYC - 1)) begin
					prev_next = rdata_reg;
					rdata_next = dq_stable_reg;
					pins_next.ce_n = 1'b1;
					pins_next.oe_n = 1'b1;
					cnt_next = 32'h0;
					state_next = ST_RD_HIGH;
				end
			end
			ST_RD_HIGH: begin
				if (cnt_reg >= 32'(GAP_CYC - 1)) begin
					cnt_next = 32'h0;
					if (poll_reg) begin
						state_next = ST_POLL;
					end else begin
						if (is_query && rdata_reg[7:0] == LOCK_ACTIVE) begin
							lock_next = 1'b1;
						end else if (is_query && rdata_reg[7:0] == LOCK_INACTIVE) begin
							lock_next = 1'b0;
						end
						pins_next = PINS_IDLE;
						state_next = ST_FINISH;
					end
				end
			end
			ST_POLL: begin
				cnt_next = 32'h0;
				first_next = 1'b0;
				if (!first_reg && settled) begin
					poll_next = 1'b0;
					if (req_reg.op == OP_LOCKOUT) begin
						lock_next = 1'b1;
					end
					pins_next = PINS_IDLE;
					state_next = ST_FINISH;
				end else if (tmo_reg >= tmo_lim) begin
					poll_next = 1'b0;
					err_next = 1'b1;
					pins_next = PINS_IDLE;
					state_next = ST_FINISH;
				end else begin
					pins_next.ce_n = 1'b0;
					pins_next.oe_n = 1'b0;
					state_next = ST_RD_LOW;
				end
			end
			ST_FINISH: begin
				cnt_next = 32'h0;
				state_next = ST_IDLE;
			end
			default: begin
				pins_next = PINS_IDLE;
				state_next = ST_IDLE;
			end
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	// a reset stands for power loss, so id mode and lock knowledge are dropped
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= ST_IDLE;
			pins_reg <= PINS_IDLE;
			req_reg <= '0;
			step_reg <= 3'h0;
			cnt_reg <= 32'h0;
			tmo_reg <= 32'h0;
			rdata_reg <= 16'h0000;
			prev_reg <= 16'h0000;
			poll_reg <= 1'b0;
			first_reg <= 1'b0;
			err_reg <= 1'b0;
			id_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			req_reg <= req_next;
			step_reg <= step_next;
			cnt_reg <= cnt_next;
			tmo_reg <= tmo_next;
			rdata_reg <= rdata_next;
			prev_reg <= prev_next;
			poll_reg <= poll_next;
			first_reg <= first_next;
			err_reg <= err_next;
			id_reg <= id_next;
			lock_reg <= lock_next;
		end
	end

	// power-up wait counter saturates once the longer delay has passed
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pu_reg <= 32'h0;
		end else if (!wr_ok || !rd_ok) begin
			pu_reg <= pu_reg + 32'h1;
		end
	end

	// data pins are asynchronous; a value is taken only when stages two and three agree
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			dq_m1_reg <= 16'h0000;
			dq_m2_reg <= 16'h0000;
			dq_m3_reg <= 16'h0000;
			dq_stable_reg <= 16'h0000;
		end else begin
			dq_m1_reg <= I_DQ;
			dq_m2_reg <= dq_m1_reg;
			dq_m3_reg <= dq_m2_reg;
			if (dq_m2_reg == dq_m3_reg) begin
				dq_stable_reg <= dq_m3_reg;
			end
		end
	end
endmodule : pfc_host
`default_nettype wire

// [sim/pfc_flash_model.sv]
// behavioural parallel flash device that answers the host's pin cycles
`default_nettype none
module pfc_flash_model
	import pfc_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h0011, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h0022, // arbitrary value
	parameter int PU_W_NS = 300
) (
	input wire logic i_rst_n,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************
	// state
	// ************
	logic [15:0] mem [0:65535];
	logic [15:0] pd, wd, hold, rd, idv;
	logic [14:0] wa;
	logic [2:0] step, nxt;
	logic id = 1'b0, lock = 1'b0, busy = 1'b0, tog = 1'b0, wsel = 1'b0, pgm = 1'b0;
	int prog_ns = 500;
	int erase_ns = 1500;
	int bt;
	time t_up = 0;
	initial for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
	initial step = 3'h0;
	initial hold = 16'h0000;
	// busy ends by itself once its time has run out
	task automatic start(input int ns);
		bt = ns;
		busy = 1'b1;
	endtask
	always @(posedge busy) begin
		#(bt);
		busy = 1'b0;
	end
	task automatic erase(input logic main_only);
		for (int i = 0; i < 65536; i++)
			if (!((lock || main_only) && i <= 16'h1FFF)) mem[i] = 16'hFFFF;
		pd = 16'hFFFF;
		start(erase_ns);
	endtask
	// latch a little after the strobe falls, so the host's pins have settled
	always @(negedge i_we_n) begin
		#1;
		wa = i_addr[14:0];
		wd = i_dq;
		wsel = !i_ce_n;
	end
	// decode on the rising strobe; anything unexpected drops back to idle
	always @(posedge i_we_n) begin
		if (wsel && !busy && $time >= t_up + PU_W_NS) begin
			nxt = 3'h0;
			if (pgm) begin
				pd = (lock && wa <= 15'h1FFF) ? mem[wa] : mem[wa] & wd;
				mem[wa] = pd;
				pgm = 1'b0;
				start(prog_ns);
			end else case (step)
				3'h0, 3'h3: if (wa == ADDR_UNLOCK1[14:0] && wd[7:0] == CODE_UNLOCK1) nxt = step + 3'h1;
					else if (step == 3'h0 && wd[7:0] == CODE_ID_EXIT) id = 1'b0;
				3'h1, 3'h4: if (wa == ADDR_UNLOCK2[14:0] && wd[7:0] == CODE_UNLOCK2) nxt = step + 3'h1;
				3'h2: if (wa == ADDR_UNLOCK1[14:0]) begin
					if (wd[7:0] == CODE_ERASE_PRE) nxt = 3'h3;
					pgm = wd[7:0] == CODE_PROGRAM;
					if (wd[7:0] == CODE_ID_ENTER) id = 1'b1;
					if (wd[7:0] == CODE_ID_EXIT) id = 1'b0;
				end
				3'h5: if (wa == ADDR_UNLOCK1[14:0]) begin
					if (wd[7:0] == CODE_LOCKOUT) lock = 1'b1;
					if (wd[7:0] == CODE_CHIP_ERASE || wd[7:0] == CODE_MAIN_ERASE) erase(wd[7:0] == CODE_MAIN_ERASE);
				end
				default: nxt = 3'h0;
			endcase
			step = nxt;
		end
	end
	// read path; a released bus shows the inverse of the last word
	assign idv = i_addr == 16'h0000 ? MAKER_ID : i_addr == 16'h0001 ? PART_ID :
		i_addr == ADDR_LOCK_QUERY ? {8'h00, lock ? LOCK_ACTIVE : LOCK_INACTIVE} : mem[i_addr];
	assign rd = busy ? {~pd[15], tog, pd[13:8], ~pd[7], tog, pd[5:0]} : id ? idv : mem[i_addr];
	assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~hold;
	always @(posedge i_oe_n) hold = rd;
	always @(negedge i_oe_n) if (busy) tog = ~tog;
	always @(negedge i_rst_n) begin
		id = 1'b0;
		step = 3'h0;
		pgm = 1'b0;
	end
	always @(posedge i_rst_n) t_up = $time;
endmodule // pfc_flash_model
`default_nettype wire

// [sim/pfc_host_checker.sv]
// pin and handshake assertions for the parallel flash host
`default_nettype none
module pfc_host_checker
	import pfc_pkg::*;
#(
	parameter int unsigned PU_WRITE_WAIT = 50,
	parameter int unsigned PU_READ_WAIT = 20
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire logic I_REQ_VALID,
	input wire pfc_req_t I_REQ,
	input wire logic O_REQ_READY,
	input wire logic O_DONE,
	input wire logic O_ERR,
	input wire logic O_ID_MODE,
	input wire logic O_LOCKED,
	input wire logic O_CE_N,
	input wire logic O_OE_N,
	input wire logic O_WE_N,
	input wire logic [15:0] O_ADDR,
	input wire logic [15:0] O_DQ,
	input wire logic O_DQ_OE_N
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	// cycles since reset, saturating so long runs never wrap
	logic [19:0] up_cnt_reg;
	wire logic acc = I_REQ_VALID && O_REQ_READY;
	wire logic boot_ref = I_REQ.op == OP_PROGRAM && O_LOCKED && I_REQ.addr <= ADDR_BOOT_END;
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) up_cnt_reg <= 20'h00000;
		else if (up_cnt_reg != 20'hFFFFF) up_cnt_reg <= up_cnt_reg + 20'h00001;
	end
	sequence take_s(pfc_op_t o);
		acc && I_REQ.op == o;
	endsequence
	sequence unlock_s;
		!O_WE_N && O_ADDR == ADDR_UNLOCK1 && O_DQ == {8'h00, CODE_UNLOCK1};
	endsequence
	read_wait_a: assert property (O_REQ_READY |-> up_cnt_reg >= PU_READ_WAIT)
		else $error("request ready before read wait");
	write_wait_a: assert property ($fell(O_WE_N) |-> up_cnt_reg >= PU_WRITE_WAIT)
		else $error("write strobe before write wait");
	strobe_width_a: assert property ($fell(O_WE_N) |-> !O_WE_N [*6] ##1 O_WE_N)
		else $error("write strobe width wrong");
	write_drive_a: assert property (!O_WE_N |-> O_OE_N && !O_DQ_OE_N && !O_CE_N)
		else $error("write cycle pins wrong");
	read_release_a: assert property (!O_OE_N |-> O_WE_N && O_DQ_OE_N)
		else $error("bus driven during read");
	unlock_first_a: assert property (acc && I_REQ.op inside {[OP_PROGRAM:OP_ID_EXIT3]} && !boot_ref |=> unlock_s)
		else $error("first unlock cycle wrong");
	read_time_a: assert property (take_s(OP_READ) |-> ##14 O_DONE)
		else $error("read done late");
	done_pulse_a: assert property (O_DONE |=> !O_DONE)
		else $error("done longer than one cycle");
	refuse_boot_a: assert property (acc && boot_ref |=> O_DONE && O_ERR && O_WE_N)
		else $error("boot program not refused");
	id_enter_a: assert property (take_s(OP_ID_ENTER) |-> ##37 O_DONE ##1 O_ID_MODE)
		else $error("id entry wrong");
	exit_one_a: assert property (take_s(OP_ID_EXIT1) |=> (!O_WE_N && O_DQ[7:0] == CODE_ID_EXIT) ##12 O_DONE ##1 !O_ID_MODE)
		else $error("single exit wrong");
endmodule // pfc_host_checker
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the parallel flash host sequencer
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", nm, (e), (g)); end end
module tb_top
	import pfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] MAKER = 16'h0011; // arbitrary value
	localparam logic [15:0] PART = 16'h0022; // arbitrary value
	logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
	pfc_req_t req = '0;
	logic ready, done, err, id_mode, locked, ce_n, oe_n, we_n, dq_oe_n;
	logic [15:0] rdata, addr, dq;
	wire logic [15:0] flash_q;
	// the wire level: host while it drives, else the device
	wire logic [15:0] dq_bus = !dq_oe_n ? dq : flash_q;
	int failures = 0;
	int tests_run = 0;
	initial forever #4 clk = ~clk;
	pfc_host #(.PROG_TIMEOUT(200), .ERASE_TIMEOUT(400), .PU_WRITE_WAIT(50), .PU_READ_WAIT(20)) dut_u (
		.I_CLOCK(clk), .I_RST_N(rst_n), .I_REQ_VALID(req_valid), .I_REQ(req), .O_REQ_READY(ready),
		.O_DONE(done), .O_ERR(err), .O_RDATA(rdata), .O_ID_MODE(id_mode), .O_LOCKED(locked),
		.O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n), .O_ADDR(addr), .O_DQ(dq), .O_DQ_OE_N(dq_oe_n), .I_DQ(dq_bus));
	pfc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .PU_W_NS(300)) flash_u (.i_rst_n(rst_n), .i_ce_n(ce_n),
		.i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr), .i_dq(dq), .o_dq(flash_q));
	// ************
	// shared tasks
	// ************
	task automatic summarize();
		if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask
	// one request, held until taken, then wait for its done pulse
	task automatic op(input pfc_op_t o, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		req = '{op: o, addr: a, data: d};
		req_valid = 1'b1;
		while (ready !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		while (done !== 1'b1 && n < 9000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 9000) begin
			failures++;
			summarize();
		end else begin
			// let the done cycle pass so the next request never re-raises valid in the same step
			@(posedge clk);
			#1;
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		op(OP_READ, a, 16'h0000);
		`CHK("read data", e, rdata)
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_power();
		do_reset();
		repeat (5) @(posedge clk);
		#1;
		`CHK("ready early", 1'b0, ready)
		`CHK("chip select idle", 1'b1, ce_n)
	endtask
	task automatic t_id();
		op(OP_PROGRAM, 16'h3000, 16'h1234);
		`CHK("program err", 1'b0, err)
		`CHK("poll data", 16'h1234, rdata)
		op(OP_ID_ENTER, 16'h0000, 16'h0000);
		`CHK("id entered", 1'b1, id_mode)
		rd(16'h0000, MAKER);
		rd(16'h0001, PART);
		rd(ADDR_LOCK_QUERY, 16'h00FE);
		`CHK("lock flag clear", 1'b0, locked)
		op(OP_ID_EXIT3, 16'h0000, 16'h0000);
		`CHK("id left", 1'b0, id_mode)
		rd(16'h3000, 16'h1234);
	endtask
	task automatic t_lock();
		op(OP_PROGRAM, 16'h0100, 16'h00AA);
		op(OP_LOCKOUT, 16'h0000, 16'h0000);
		`CHK("locked", 1'b1, locked)
		op(OP_PROGRAM, ADDR_BOOT_END, 16'h0000);
		`CHK("boot refused", 1'b1, err)
		op(OP_CHIP_ERASE, 16'h0000, 16'h0000);
		`CHK("erase err", 1'b0, err)
		`CHK("erase poll data", 16'hFFFF, rdata)
		rd(16'h0100, 16'h00AA);
		rd(16'h3000, 16'hFFFF);
		rd(ADDR_BOOT_END, 16'hFFFF);
		op(OP_ID_ENTER, 16'h0000, 16'h0000);
		rd(ADDR_LOCK_QUERY, 16'h00FF);
		op(OP_ID_EXIT1, 16'h7777, 16'h0000);
		`CHK("single exit", 1'b0, id_mode)
		rd(16'h0100, 16'h00AA);
	endtask
	task automatic t_main();
		op(OP_PROGRAM, 16'h4000, 16'h0F0F);
		op(OP_MAIN_ERASE, 16'h0000, 16'h0000);
		rd(16'h4000, 16'hFFFF);
		rd(16'h0100, 16'h00AA);
	endtask
	// a device slower than the limit must end in an error
	task automatic t_timeout();
		flash_u.prog_ns = 4000;
		op(OP_PROGRAM, 16'h5000, 16'h1111);
		`CHK("program timeout", 1'b1, err)
		flash_u.prog_ns = 500;
		repeat (500) @(posedge clk);
		#1;
	endtask
	task automatic t_reset_mid();
		op(OP_ID_ENTER, 16'h0000, 16'h0000);
		do_reset();
		`CHK("id after reset", 1'b0, id_mode)
		`CHK("lock after reset", 1'b0, locked)
		rd(16'h0000, 16'hFFFF);
	endtask
	initial begin
		t_power();
		t_id();
		t_lock();
		t_main();
		t_timeout();
		t_reset_mid();
		summarize();
	end
endmodule // tb_top
bind pfc_host pfc_host_checker #(.PU_WRITE_WAIT(PU_WRITE_WAIT), .PU_READ_WAIT(PU_READ_WAIT)) chk_u (
	.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY),
	.O_DONE(O_DONE), .O_ERR(O_ERR), .O_ID_MODE(O_ID_MODE), .O_LOCKED(O_LOCKED), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N),
	.O_WE_N(O_WE_N), .O_ADDR(O_ADDR), .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N));
`default_nettype wire
